/* hdl/rxmpo_top.sv */
// rxmpo_top: drives the receive data bus, its parity and the start-of-cell marker
// assumes the link layer runs on REF_CLK and per-port FIFOs show their head word
module rxmpo_top
   import rxmpo_pkg::*;
#(
   parameter int          NUM_PORTS = rxmpo_pkg::NUM_PORTS,
   parameter logic [2:0]  PORT_BASE = rxmpo_pkg::PORT_BASE_DFLT
) (
   input  wire logic                                   REF_CLK,
   input  wire logic                                   SRST,
   input  wire logic                                   READ_EN_N,
   input  wire logic [rxmpo_pkg::ADDR_W-1:0]           RX_ADDR,
   input  wire logic                                   PACKET_MODE,
   input  wire logic                                   RX_PARITY_TYPE_SELECT,
   input  wire logic [NUM_PORTS*rxmpo_pkg::DATA_W-1:0] FIFO_HEAD_DATA,
   input  wire logic [NUM_PORTS-1:0]                   FIFO_HEAD_SOC,
   input  wire logic [NUM_PORTS-1:0]                   FIFO_EMPTY,
   output logic      [NUM_PORTS-1:0]                   FIFO_POP,
   output logic      [rxmpo_pkg::DATA_W-1:0]           RDAT_OUT,
   output logic      [rxmpo_pkg::DATA_W-1:0]           RDAT_OE,
   output logic                                        RPRTY_OUT,
   output logic                                        RPRTY_OE,
   output logic                                        RSOC_OUT,
   output logic                                        RSOC_OE
);

   // address decode: true when the code names one of this device's ports
   function automatic logic addr_in_space(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] off;
      off = a - PORT_BASE;
      addr_in_space = (a != NULL_ADDR) && (a >= PORT_BASE) && (int'(off) < NUM_PORTS);
   endfunction

   // port index of an in-space address
   function automatic rxmpo_port_t addr_to_port(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] off;
      off = a - PORT_BASE;
      addr_to_port = off[1:0];
   endfunction

   // latched selection and bus phase
   // the latched address starts null, so nothing drives until the link
   // has spent one cycle with read enable high on a valid port code
   logic [ADDR_W-1:0] sel_addr_reg;
   logic [ADDR_W-1:0] sel_addr_next;
   rxmpo_phase_e      phase_reg;
   rxmpo_phase_e      phase_next;

   // output drive state
   logic [DATA_W-1:0] data_reg;
   logic [DATA_W-1:0] data_next;
   logic              drive_reg;
   logic              drive_next;
   logic              prty_reg;
   logic              prty_next;
   logic              soc_reg;
   logic              soc_next;
   logic              soc_drive_reg;
   logic              soc_drive_next;

   // selection decode and chosen word
   logic              sel_valid;
   rxmpo_port_t       sel_port;
   logic [DATA_W-1:0] head_word;
   logic              head_soc;
   logic              head_prty;
   logic              head_ready;
   logic              do_read;

   assign sel_valid  = addr_in_space(sel_addr_reg);
   assign sel_port   = addr_to_port(sel_addr_reg);
   assign head_ready = sel_valid && !FIFO_EMPTY[sel_port];
   // a word leaves the FIFO only in a read cycle on a valid, non-empty port
   assign do_read    = !READ_EN_N && head_ready;

   // head word, start marker and parity of the selected port
   rxmpo_word_sel #(
      .DATA_W    (DATA_W),
      .NUM_PORTS (NUM_PORTS),
      .SEL_W     (2)
   ) u_word_sel (
      .head_data (FIFO_HEAD_DATA),
      .head_soc  (FIFO_HEAD_SOC),
      .port      (sel_port),
      .odd_sel   (RX_PARITY_TYPE_SELECT),
      .word      (head_word),
      .soc       (head_soc),
      .parity    (head_prty)
   );

   // selection: enable sampled high latches the address, low keeps it
   always_comb begin
      sel_addr_next = sel_addr_reg;
      phase_next    = phase_reg;
      if (READ_EN_N) begin
         sel_addr_next = RX_ADDR;
         phase_next    = RXMPO_PH_SELECT;
      end else begin
         phase_next    = RXMPO_PH_TRANSFER;
      end
   end

   // output drive: float while selecting or on a null/foreign address
   always_comb begin
      data_next      = data_reg;
      prty_next      = prty_reg;
      soc_next       = SOC_RST;
      drive_next     = OE_RST;
      soc_drive_next = OE_RST;
      if (!READ_EN_N && sel_valid) begin
         // data and parity pins leave float on the same edge; the start marker does so only in cell mode
         drive_next     = 1'b1;
         soc_drive_next = !PACKET_MODE;
         if (head_ready) begin
            // cells in cell mode, 16-bit packet words in packet mode
            data_next = head_word;
            prty_next = head_prty;
            soc_next  = !PACKET_MODE && head_soc;
         end
      end
   end

   // selection and phase registers
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         sel_addr_reg <= SEL_RST;
         phase_reg    <= RXMPO_PH_SELECT;
      end else begin
         sel_addr_reg <= sel_addr_next;
         phase_reg    <= phase_next;
      end
   end

   // data and parity registers, changed on the rising edge only
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         data_reg <= DATA_RST;
         prty_reg <= PRTY_RST;
      end else begin
         data_reg <= data_next;
         prty_reg <= prty_next;
      end
   end

   // drive enables and start marker
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         drive_reg     <= OE_RST;
         soc_reg       <= SOC_RST;
         soc_drive_reg <= OE_RST;
      end else begin
         drive_reg     <= drive_next;
         soc_reg       <= soc_next;
         soc_drive_reg <= soc_drive_next;
      end
   end

   // pop the head word taken at this edge
   // combinational on purpose: a registered pop would lag one cycle and
   // hand the same head word twice during back-to-back reads
   always_comb begin
      FIFO_POP = '0;
      if (do_read) begin
         FIFO_POP[sel_port] = 1'b1;
      end
   end

   // pin outputs straight from the registers
   // every enable bit of the data bus follows one flop, so the pads
   // cannot leave float on different edges
   always_comb begin
      RDAT_OUT  = data_reg;
      RDAT_OE   = {DATA_W{drive_reg}};
      RPRTY_OUT = prty_reg;
      RPRTY_OE  = drive_reg;
      RSOC_OUT  = soc_reg;
      RSOC_OE   = soc_drive_reg;
   end

endmodule

/* hdl/rxmpo_word_sel.sv */
// rxmpo_word_sel: picks the head word of one port FIFO and forms its parity
// assumes FIFO heads are presented flat, port 0 in the low slice; purely combinational
module rxmpo_word_sel #(
   parameter int DATA_W    = 16,
   parameter int NUM_PORTS = 4,
   parameter int SEL_W     = 2
) (
   input  wire logic [NUM_PORTS*DATA_W-1:0] head_data,
   input  wire logic [NUM_PORTS-1:0]        head_soc,
   input  wire logic [SEL_W-1:0]            port,
   input  wire logic                        odd_sel,
   output logic      [DATA_W-1:0]           word,
   output logic                             soc,
   output logic                             parity
);

   // per-port slices of the flat head bus
   logic [DATA_W-1:0] slice [NUM_PORTS];

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : g_slice
         assign slice[g] = head_data[g*DATA_W +: DATA_W];
      end
   endgenerate

   // parity over all data bits; odd sense inverts the even result
   function automatic logic word_parity(input logic [DATA_W-1:0] w, input logic odd);
      word_parity = (^w) ^ odd;
   endfunction

   // word, start marker and parity of the chosen port
   always_comb begin
      word   = slice[port];
      soc    = head_soc[port];
      parity = word_parity(slice[port], odd_sel);
   end

endmodule

/* include/rxmpo_pkg.sv */
// rxmpo_pkg: constants shared by the receive multi-port output drive block
// assumes the block sits behind four per-port receive FIFOs on one clock
package rxmpo_pkg;

   // bus widths and port count
   localparam int DATA_W    = 16;
   localparam int ADDR_W    = 3;
   localparam int NUM_PORTS = 4;

   // address decode: null port code and the first port code of this device
   localparam logic [2:0] NULL_ADDR       = 3'h7;
   localparam logic [2:0] PORT_BASE_DFLT  = 3'h0;

   // reset values of the selection and output drive state
   localparam logic [15:0] DATA_RST  = 16'h0000;
   localparam logic [2:0]  SEL_RST   = 3'h7;
   localparam logic        OE_RST    = 1'b0;
   localparam logic        PRTY_RST  = 1'b0;
   localparam logic        SOC_RST   = 1'b0;

   // bus phase registered by the selection logic
   typedef enum logic [1:0] {
      RXMPO_PH_SELECT   = 2'b01,
      RXMPO_PH_TRANSFER = 2'b10
   } rxmpo_phase_e;

   // width helper for the port select
   typedef logic [1:0] rxmpo_port_t;

endpackage

/* verification/rxmpo_fifo_model.sv */
// rxmpo_fifo_model: four receive port FIFOs seen from their heads
// assumes pops are one-cycle pulses; each port holds DEPTH words, cells of three
module rxmpo_fifo_model #(parameter int DEPTH = 7) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [3:0]  pop,
   output logic      [63:0] head_data,
   output logic      [3:0]  head_soc,
   output logic      [3:0]  empty
);
   int cnt [4];
   // one word leaves a port per pop
   always_ff @(posedge clk) begin
      for (int p = 0; p < 4; p++)
         if (srst) cnt[p] <= 0;
         else if (pop[p]) cnt[p] <= cnt[p] + 1;
   end
   // head word names port and position; a drained port shows garbage
   always_comb begin
      logic [15:0] w;
      w = 16'h0000;
      for (int p = 0; p < 4; p++) begin
         w = 16'hA000 | 16'(p * 256 + cnt[p]);
         empty[p] = cnt[p] >= DEPTH;
         head_data[p*16 +: 16] = empty[p] ? ~w : w;
         head_soc[p] = (cnt[p] % 3 == 0) ^ empty[p];
      end
   end
endmodule

/* verification/rxmpo_test.sv */
// rxmpo_test: drives select and read cycles and checks the receive bus
// assumes the FIFO model holds seven words per port
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module rxmpo_test;
   import rxmpo_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, ren_n = 1, pkt = 0, odd = 0, prty, prty_oe, soc, soc_oe;
   logic [2:0] addr = 3'h7;
   logic [63:0] head;
   logic [3:0] hsoc, empty, pop;
   logic [15:0] dat, dat_oe, last;
   int err_total = 0, tests_run = 0, cycles = 0, cnt [8] = '{default: 0};
   rxmpo_top i_rxmpo_top (.REF_CLK(clk), .SRST(srst), .READ_EN_N(ren_n), .RX_ADDR(addr), .PACKET_MODE(pkt),
      .RX_PARITY_TYPE_SELECT(odd), .FIFO_HEAD_DATA(head), .FIFO_HEAD_SOC(hsoc), .FIFO_EMPTY(empty),
      .FIFO_POP(pop), .RDAT_OUT(dat), .RDAT_OE(dat_oe), .RPRTY_OUT(prty), .RPRTY_OE(prty_oe),
      .RSOC_OUT(soc), .RSOC_OE(soc_oe));
   rxmpo_fifo_model i_rxmpo_fifo_model (.clk(clk), .srst(srst), .pop(pop), .head_data(head), .head_soc(hsoc),
      .empty(empty));
   always #5 clk = ~clk;
   // cycle ceiling against hangs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (err_total == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // select port a, read n words back to back, then deselect
   task automatic rd(input logic [2:0] a, input int n);
      logic esoc;
      @(posedge clk);
      ren_n <= 1'b1;
      addr <= a;
      @(posedge clk);
      ren_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (i == n - 1) ren_n <= 1'b1;
         #1;
         esoc = 1'b0;
         if (a > 3) `CHK("float", 18'h0, {dat_oe, prty_oe, soc_oe})
         else begin
            if (cnt[a] < 7) begin
               last = 16'hA000 | 16'(a * 256 + cnt[a]);
               esoc = cnt[a] % 3 == 0;
               cnt[a]++;
            end
            `CHK("enables", {16'hFFFF, 1'b1, !pkt}, {dat_oe, prty_oe, soc_oe})
            `CHK("data", last, dat)
            `CHK("parity", ^last ^ odd, prty)
            if (!pkt) `CHK("soc", esoc, soc)
         end
      end
      @(posedge clk);
      #1;
      `CHK("idle", 18'h0, {dat_oe, prty_oe, soc_oe})
   endtask
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      #1;
      `CHK("reset", 18'h0, {dat_oe, prty_oe, soc_oe})
      rd(3'h0, 4);
      rd(3'h7, 2);
      rd(3'h5, 2);
      rd(3'h0, 3);
      @(posedge clk);
      odd <= 1'b1;
      rd(3'h1, 5);
      rd(3'h3, 2);
      @(posedge clk);
      pkt <= 1'b1;
      odd <= 1'b0;
      rd(3'h2, 9);
      rd(3'h1, 3);
      tally_and_finish();
   end
endmodule

/* verification/rxmpo_top_asserts.sv */
// rxmpo_top_asserts: port checks of the receive output drive
// assumes one clock domain and a synchronous active-high reset
module rxmpo_top_asserts #(
   parameter int         NUM_PORTS = 4,
   parameter logic [2:0] PORT_BASE = 3'h0
) (
   input wire logic                    REF_CLK,
   input wire logic                    SRST,
   input wire logic                    READ_EN_N,
   input wire logic [2:0]              RX_ADDR,
   input wire logic                    PACKET_MODE,
   input wire logic                    RX_PARITY_TYPE_SELECT,
   input wire logic [NUM_PORTS*16-1:0] FIFO_HEAD_DATA,
   input wire logic [NUM_PORTS-1:0]    FIFO_POP,
   input wire logic [15:0]             RDAT_OUT,
   input wire logic [15:0]             RDAT_OE,
   input wire logic                    RPRTY_OUT,
   input wire logic                    RPRTY_OE,
   input wire logic                    RSOC_OE
);
   int pop_idx;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   // index of the port being popped
   always_comb begin
      pop_idx = 0;
      for (int i = 0; i < NUM_PORTS; i++)
         if (FIFO_POP[i]) pop_idx = i;
   end
   a_float_desel: assert property (READ_EN_N |=> RDAT_OE == 16'h0000 && !RPRTY_OE && !RSOC_OE)
      else $error("outputs driven after deselect");
   a_bad_addr: assert property (READ_EN_N && (RX_ADDR == 3'h7 || RX_ADDR - PORT_BASE >= NUM_PORTS)
      ##1 !READ_EN_N |=> RDAT_OE == 16'h0000 && !RPRTY_OE && !RSOC_OE) else $error("bad address drives bus");
   a_sel_drive: assert property (READ_EN_N && RX_ADDR - PORT_BASE < NUM_PORTS ##1 !READ_EN_N
      |=> RDAT_OE == 16'hFFFF && RPRTY_OE && RSOC_OE != $past(PACKET_MODE)) else $error("select not driven");
   a_oe_together: assert property (RDAT_OE == {16{RPRTY_OE}})
      else $error("data and parity enables differ");
   a_parity_ok: assert property (RPRTY_OE |-> RPRTY_OUT == (^RDAT_OUT ^ $past(RX_PARITY_TYPE_SELECT)))
      else $error("parity wrong");
   a_pop_one: assert property (FIFO_POP != 0 |-> $onehot(FIFO_POP) && !READ_EN_N)
      else $error("pop without read");
   a_pop_data: assert property (FIFO_POP != 0 |=> RDAT_OUT == $past(FIFO_HEAD_DATA[pop_idx*16 +: 16]))
      else $error("popped word not shown");
   a_pkt_no_soc: assert property (PACKET_MODE |=> !RSOC_OE)
      else $error("start of cell driven in packet mode");
endmodule
bind rxmpo_top rxmpo_top_asserts #(.NUM_PORTS(NUM_PORTS), .PORT_BASE(PORT_BASE)) i_rxmpo_top_asserts (.REF_CLK,
   .SRST, .READ_EN_N, .RX_ADDR, .PACKET_MODE, .RX_PARITY_TYPE_SELECT, .FIFO_HEAD_DATA, .FIFO_POP, .RDAT_OUT,
   .RDAT_OE, .RPRTY_OUT, .RPRTY_OE, .RSOC_OE);
